//--- pec_pkg.sv
// Purpose: shared constants for the extended control register block
// Assumes: 16-bit management registers addressed by a 5-bit register number
// Notes: field positions and reset values of the extended control register
package pec_pkg;
    localparam logic [4:0] PEC_EXT_CTRL_OFS = 5'h10;
    localparam int PEC_OVR_BIT = 15;
    localparam int PEC_ADDR_HI = 10;
    localparam int PEC_ADDR_LO = 6;
    localparam int PEC_SCR_TEST_BIT = 5;
    localparam int PEC_NRZI_BIT = 3;
    localparam int PEC_INV_CODE_BIT = 2;
    localparam int PEC_SCR_DIS_BIT = 0;
    localparam logic PEC_OVR_RST = 1'h0;
    localparam logic PEC_SCR_TEST_RST = 1'h0;
    localparam logic PEC_NRZI_RST = 1'h1;
    localparam logic PEC_INV_CODE_RST = 1'h0;
    localparam logic PEC_SCR_DIS_RST = 1'h0;
    localparam logic [4:0] PEC_ADDR_RST = 5'h00;
    localparam logic [15:0] PEC_RDATA_RST = 16'h0000;
    localparam logic [10:0] PEC_LFSR_SEED = 11'h7FF;
    localparam logic [1:0] PEC_STRAP_WAIT = 2'h3;
    localparam logic [4:0] PEC_CODE_HALT = 5'h04;
    localparam int PEC_CODE_W = 5;
endpackage

//--- pec_stream_if.sv
// Purpose: valid/ready carrier for encoded five-bit code groups
// Assumes: one clock domain
// Notes: on the buffer input side, ready is driven from a flip-flop inside the buffer; on its output side ready comes from the sink
`timescale 1ns/10ps
`default_nettype none
interface pec_stream_if;
    logic valid;
    logic ready;
    logic [4:0] data;
    modport src (output valid, output data, input ready);
    modport dst (input valid, input data, output ready);
endinterface
`default_nettype wire

//--- pec_buf2.sv
// Purpose: two-entry buffer for code groups, head word comes from a register
// Assumes: synchronous active-low reset
// Notes: ready is registered, so it drops only when both entries are full and rises the cycle after a pop frees the tail
`timescale 1ns/10ps
`default_nettype none
module pec_buf2
    import pec_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    pec_stream_if.dst in_s,
    pec_stream_if.src out_s
);
    logic [4:0] head_ff;
    logic [4:0] tail_ff;
    logic head_v_ff;
    logic tail_v_ff;
    logic free_ff;
    logic [4:0] nxt_head;
    logic [4:0] nxt_tail;
    logic nxt_head_v;
    logic nxt_tail_v;

    // -----------------------------------------
    // push / pop decode
    // -----------------------------------------
    wire push = in_s.valid & free_ff;
    wire pop = head_v_ff & out_s.ready;

    // head refills from the tail first so order is kept
    always_comb begin
        nxt_head = head_ff;
        nxt_tail = tail_ff;
        nxt_head_v = head_v_ff;
        nxt_tail_v = tail_v_ff;
        if (pop) begin
            if (tail_v_ff) begin
                nxt_head = tail_ff;
                nxt_tail_v = 1'b0;
            end else begin
                nxt_head = in_s.data;
                nxt_head_v = push;
            end
        end else if (push) begin
            if (!head_v_ff) begin
                nxt_head = in_s.data;
                nxt_head_v = 1'b1;
            end else begin
                nxt_tail = in_s.data;
                nxt_tail_v = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            head_v_ff <= 1'b0;
            tail_v_ff <= 1'b0;
            free_ff <= 1'b0;
            head_ff <= 5'h00;
            tail_ff <= 5'h00;
        end else begin
            head_v_ff <= nxt_head_v;
            tail_v_ff <= nxt_tail_v;
            free_ff <= ~nxt_tail_v;
            head_ff <= nxt_head;
            tail_ff <= nxt_tail;
        end
    end

    assign in_s.ready = free_ff;
    assign out_s.valid = head_v_ff;
    assign out_s.data = head_ff;
endmodule
`default_nettype wire

//--- pec_ext_ctrl.sv
// Purpose: extended control register and the transmit code path it steers
// Assumes: management frames already decoded into register strobes
// Notes: one clock; the LED pins are straps sampled after reset release
//
// Functional notes
// - arming the override bit lets the next management write change protected bits
// - override enable clears itself after the next management write
// - reserved bits 14..11, 4 and 1 read as zero
// - bits 10..6 read the five-bit management port address
// - port address sampled from LED pins after hardware reset release and latched
// - software reset leaves the latched port address alone
// - stream cipher test bit forces descrambler out of lock; resets to zero
// - 100M serial stream NRZ when bit is zero, NRZI when one; resets one
// - invalid code bit zero gives standard 4B/5B translation; resets zero
// - test mode with tx error maps nibbles 0..7 to zero-led groups
// - test mode with tx error maps nibbles 8..F to the fixed invalid code table
// - cipher disable bit bypasses scrambler and descrambler; resets zero
// - scrambling applies only in 100M operation
`timescale 1ns/10ps
`default_nettype none
module pec_ext_ctrl
    import pec_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic sw_rst,
    input wire logic mgmt_wr_stb,
    input wire logic mgmt_rd_stb,
    input wire logic [4:0] mgmt_reg_addr,
    input wire logic [15:0] mgmt_wdata,
    output logic [15:0] mgmt_rdata,
    output logic cmd_override_en,
    output logic [4:0] phy_addr,
    input wire logic [4:0] addr_led_pins,
    input wire logic speed_100,
    input wire logic tx_nib_valid,
    input wire logic [3:0] tx_nib,
    input wire logic tx_er,
    output logic tx_nib_ready,
    output logic tx_code_valid,
    output logic [4:0] tx_code,
    input wire logic tx_code_ready,
    output logic scr_bypass,
    output logic descr_bypass,
    output logic descr_force_unlock
);
    // -----------------------------------------
    // functions
    // -----------------------------------------
    function automatic logic [4:0] std_4b5b(input logic [3:0] n);
        logic [4:0] c;
        c = 5'h1E;
        case (n)
            4'h0: c = 5'h1E;
            4'h1: c = 5'h09;
            4'h2: c = 5'h14;
            4'h3: c = 5'h15;
            4'h4: c = 5'h0A;
            4'h5: c = 5'h0B;
            4'h6: c = 5'h0E;
            4'h7: c = 5'h0F;
            4'h8: c = 5'h12;
            4'h9: c = 5'h13;
            4'hA: c = 5'h16;
            4'hB: c = 5'h17;
            4'hC: c = 5'h1A;
            4'hD: c = 5'h1B;
            4'hE: c = 5'h1C;
            default: c = 5'h1D;
        endcase
        return c;
    endfunction

    function automatic logic [4:0] inv_4b5b(input logic [3:0] n);
        logic [4:0] c;
        c = {1'b0, n};
        case (n)
            4'h8: c = 5'h00;
            4'h9: c = 5'h0D;
            4'hA: c = 5'h0C;
            4'hB: c = 5'h11;
            4'hC: c = 5'h10;
            4'hD: c = 5'h19;
            4'hE: c = 5'h18;
            4'hF: c = 5'h1F;
            default: c = {1'b0, n};
        endcase
        return c;
    endfunction

    // -----------------------------------------
    // control register
    // -----------------------------------------
    logic ovr_ff;
    logic scr_test_ff;
    logic nrzi_ff;
    logic inv_code_ff;
    logic scr_dis_ff;
    logic [15:0] rdata_ff;
    logic [4:0] addr_ff;

    wire sel_ext = (mgmt_reg_addr == PEC_EXT_CTRL_OFS);
    wire wr_ext = mgmt_wr_stb & sel_ext;
    // arm on own write, clear on any other write; arming wins
    wire nxt_ovr = wr_ext ? mgmt_wdata[PEC_OVR_BIT] : (mgmt_wr_stb ? 1'b0 : ovr_ff);
    // reserved positions stay zero, address is read-only view
    wire [15:0] rd_word = {ovr_ff, 4'h0, addr_ff, scr_test_ff, 1'b0, nrzi_ff,
        inv_code_ff, 1'b0, scr_dis_ff};

    // hardware or software reset restores control defaults
    always_ff @(posedge sys_clk) begin
        if (!rst_n || sw_rst) begin
            ovr_ff <= PEC_OVR_RST;
            scr_test_ff <= PEC_SCR_TEST_RST;
            nrzi_ff <= PEC_NRZI_RST;
            inv_code_ff <= PEC_INV_CODE_RST;
            scr_dis_ff <= PEC_SCR_DIS_RST;
        end else begin
            ovr_ff <= nxt_ovr;
            if (wr_ext) begin
                scr_test_ff <= mgmt_wdata[PEC_SCR_TEST_BIT];
                nrzi_ff <= mgmt_wdata[PEC_NRZI_BIT];
                inv_code_ff <= mgmt_wdata[PEC_INV_CODE_BIT];
                scr_dis_ff <= mgmt_wdata[PEC_SCR_DIS_BIT];
            end
        end
    end

    // read data held until the next read strobe
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rdata_ff <= PEC_RDATA_RST;
        end else if (mgmt_rd_stb) begin
            rdata_ff <= sel_ext ? rd_word : 16'h0000;
        end
    end

    // -----------------------------------------
    // port address strap
    // -----------------------------------------
    logic [4:0] pin_s1_ff;
    logic [4:0] pin_s2_ff;
    logic [4:0] pin_s3_ff;
    logic [4:0] pin_filt_ff;
    logic [1:0] strap_cnt_ff;
    logic strap_done_ff;

    // pins are asynchronous, so a change counts once stages two and three agree
    always_ff @(posedge sys_clk) begin
        pin_s1_ff <= addr_led_pins;
        pin_s2_ff <= pin_s1_ff;
        pin_s3_ff <= pin_s2_ff;
        if (pin_s2_ff == pin_s3_ff) begin
            pin_filt_ff <= pin_s3_ff;
        end
    end

    // capture once after hardware reset, wait for the chain to fill
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            strap_cnt_ff <= 2'h0;
            strap_done_ff <= 1'b0;
            addr_ff <= PEC_ADDR_RST;
        end else if (!strap_done_ff) begin
            strap_cnt_ff <= strap_cnt_ff + 2'h1;
            if (strap_cnt_ff == PEC_STRAP_WAIT) begin
                strap_done_ff <= 1'b1;
                addr_ff <= pin_filt_ff;
            end
        end
    end

    // -----------------------------------------
    // transmit code path
    // -----------------------------------------
    pec_stream_if code_in ();
    pec_stream_if code_out ();
    logic [10:0] lfsr_ff;
    logic line_ff;
    logic [4:0] scr_code;
    logic [4:0] enc_code;
    logic [10:0] nxt_lfsr;
    logic nxt_line;

    // pick translation by test bit and tx error
    wire use_inv = inv_code_ff & tx_er;
    wire [4:0] raw_code = use_inv ? inv_4b5b(tx_nib) : (tx_er ? PEC_CODE_HALT : std_4b5b(tx_nib));
    // cipher only at 100M and when not disabled
    wire scr_on = speed_100 & ~scr_dis_ff;
    wire push = tx_nib_valid & code_in.ready;

    // scramble and line-code the group first bit first (msb)
    always_comb begin
        nxt_lfsr = lfsr_ff;
        nxt_line = line_ff;
        scr_code = raw_code;
        enc_code = raw_code;
        for (int i = PEC_CODE_W - 1; i >= 0; i--) begin
            scr_code[i] = raw_code[i] ^ (scr_on & (nxt_lfsr[10] ^ nxt_lfsr[8]));
            nxt_lfsr = {nxt_lfsr[9:0], nxt_lfsr[10] ^ nxt_lfsr[8]};
            // invert on one when NRZI is chosen at 100M
            nxt_line = nxt_line ^ scr_code[i];
            enc_code[i] = (nrzi_ff & speed_100) ? nxt_line : scr_code[i];
        end
    end

    // lfsr and line level only step when a group is really taken
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            lfsr_ff <= PEC_LFSR_SEED;
            line_ff <= 1'b0;
        end else if (push) begin
            lfsr_ff <= nxt_lfsr;
            line_ff <= nxt_line;
        end
    end

    assign code_in.valid = tx_nib_valid;
    assign code_in.data = enc_code;
    assign code_out.ready = tx_code_ready;

    pec_buf2 u_buf (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .in_s(code_in),
        .out_s(code_out)
    );

    // -----------------------------------------
    // registered control outputs
    // -----------------------------------------
    logic scr_byp_ff;
    logic descr_unlock_ff;
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            scr_byp_ff <= 1'b1;
            descr_unlock_ff <= 1'b0;
        end else begin
            scr_byp_ff <= ~scr_on;
            // hold descrambler out of lock while test bit is set
            descr_unlock_ff <= scr_test_ff;
        end
    end

    assign mgmt_rdata = rdata_ff;
    assign cmd_override_en = ovr_ff;
    assign phy_addr = addr_ff;
    assign tx_nib_ready = code_in.ready;
    assign tx_code_valid = code_out.valid;
    assign tx_code = code_out.data;
    assign scr_bypass = scr_byp_ff;
    assign descr_bypass = scr_byp_ff;
    assign descr_force_unlock = descr_unlock_ff;

    // -----------------------------------------
    // checks
    // -----------------------------------------
    ovr_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        mgmt_wr_stb && !wr_ext && !sw_rst |=> !cmd_override_en)
        else $error("override enable survived a write");
    ovr_arm_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wr_ext && mgmt_wdata[PEC_OVR_BIT] && !sw_rst |=> cmd_override_en)
        else $error("override enable not armed");
    rsvd_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        mgmt_rd_stb |=> (mgmt_rdata[14:11] == 4'h0) && !mgmt_rdata[4] && !mgmt_rdata[1])
        else $error("reserved bit read nonzero");
    addr_view_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        mgmt_rd_stb && sel_ext |=> mgmt_rdata[10:6] == phy_addr)
        else $error("address field mismatch");
    addr_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        strap_done_ff |=> $stable(phy_addr))
        else $error("latched address changed");
    nrzi_rst_a: assert property (@(posedge sys_clk)
        !rst_n |=> nrzi_ff && !scr_dis_ff && !inv_code_ff && !scr_test_ff)
        else $error("control bits not at defaults");
    unlock_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        1'b1 |=> descr_force_unlock == $past(scr_test_ff))
        else $error("descrambler not forced out of lock");
    cipher_10m_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !speed_100 |=> scr_bypass)
        else $error("cipher active at 10M");
    inv_map_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        use_inv && !tx_nib[3] |-> raw_code == {1'b0, tx_nib})
        else $error("invalid code low half wrong");
    inv_hi_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        use_inv && tx_nib == 4'h9 |-> raw_code == 5'h0D)
        else $error("invalid code high half wrong");
    std_map_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !inv_code_ff && !tx_er && tx_nib == 4'h0 |-> raw_code == 5'h1E)
        else $error("standard translation wrong");
    byp_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        scr_dis_ff |=> descr_bypass)
        else $error("cipher not bypassed");
endmodule
`default_nettype wire

//--- pec_sta_model.sv
// Purpose: station manager model issuing register strobes
// Assumes: one strobe cycle per access, read data one edge later
// Notes: bus lines turn to junk between accesses
`timescale 1ns/10ps
`default_nettype none
module pec_sta_model (
    input wire logic sys_clk,
    output logic mgmt_wr_stb,
    output logic mgmt_rd_stb,
    output logic [4:0] mgmt_reg_addr,
    output logic [15:0] mgmt_wdata,
    input wire logic [15:0] mgmt_rdata
);
    initial begin
        mgmt_wr_stb = 1'b0;
        mgmt_rd_stb = 1'b0;
        mgmt_reg_addr = 5'h00;
        mgmt_wdata = 16'h0000;
    end
    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    // raw cycle; inverted lines afterwards so stale values never look valid
    task automatic cyc(input logic w, input logic [4:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        mgmt_wr_stb <= w;
        mgmt_rd_stb <= !w;
        mgmt_reg_addr <= a;
        mgmt_wdata <= d;
        @(posedge sys_clk);
        mgmt_wr_stb <= 1'b0;
        mgmt_rd_stb <= 1'b0;
        mgmt_reg_addr <= ~a;
        mgmt_wdata <= ~d;
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        cyc(1'b1, a, d & 16'h802D);
    endtask
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        cyc(1'b0, a, 16'h0000);
        @(posedge sys_clk);
        #1 d = mgmt_rdata;
    endtask
    // arm again before each protected write
    task automatic arm_wr(input logic [15:0] ctl, input logic [4:0] a, input logic [15:0] d);
        wr(5'h10, ctl | 16'h8000);
        wr(a, d);
    endtask
endmodule
`default_nettype wire

//--- tb_top.sv
// Purpose: self-checking bench for the extended control register block
// Assumes: pec_ext_ctrl top, pec_sta_model drives the register strobes
// Notes: data checked in five mode settings (no scrambled NRZ run), scrambled groups against a bench lfsr model
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import pec_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic sw_rst = 1'b0;
    logic speed_100 = 1'b0;
    logic tx_nib_valid = 1'b0;
    logic [3:0] tx_nib = 4'h0;
    logic tx_er = 1'b0;
    logic tx_code_ready = 1'b0;
    logic [4:0] addr_led_pins = 5'h00;
    logic mgmt_wr_stb, mgmt_rd_stb, cmd_override_en, tx_nib_ready, tx_code_valid;
    logic scr_bypass, descr_bypass, descr_force_unlock;
    logic [4:0] mgmt_reg_addr, phy_addr, tx_code, pins;
    logic [15:0] mgmt_wdata, mgmt_rdata, rv;
    logic [15:0] aw;
    logic [10:0] lf;
    logic c_inv, c_nrzi, c_dis, lv, er_all, stall;
    logic [3:0] nib_x;
    logic [4:0] expq[$];
    int n_fail = 0;
    int tests_run = 0;
    int n_off = 0;
    int i;
    localparam logic [0:15][4:0] STD_C = {5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B,
        5'h0E, 5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
    localparam logic [0:7][4:0] INV_HI = {5'h00, 5'h0D, 5'h0C, 5'h11, 5'h10, 5'h19,
        5'h18, 5'h1F};

    always #5 sys_clk = ~sys_clk;

    pec_ext_ctrl pec_ext_ctrl_inst (.sys_clk(sys_clk), .rst_n(rst_n), .sw_rst(sw_rst),
        .mgmt_wr_stb(mgmt_wr_stb), .mgmt_rd_stb(mgmt_rd_stb),
        .mgmt_reg_addr(mgmt_reg_addr), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
        .cmd_override_en(cmd_override_en), .phy_addr(phy_addr),
        .addr_led_pins(addr_led_pins), .speed_100(speed_100), .tx_nib_valid(tx_nib_valid),
        .tx_nib(tx_nib), .tx_er(tx_er), .tx_nib_ready(tx_nib_ready),
        .tx_code_valid(tx_code_valid), .tx_code(tx_code), .tx_code_ready(tx_code_ready),
        .scr_bypass(scr_bypass), .descr_bypass(descr_bypass),
        .descr_force_unlock(descr_force_unlock));
    pec_sta_model pec_sta_model_inst (.sys_clk(sys_clk), .mgmt_wr_stb(mgmt_wr_stb),
        .mgmt_rd_stb(mgmt_rd_stb), .mgmt_reg_addr(mgmt_reg_addr),
        .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata));

    // ------------------------------------------------------------
    // expectations and checking
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    function automatic logic [4:0] enc(input logic [3:0] n, input logic e);
        if (e && c_inv) return n[3] ? INV_HI[n[2:0]] : {1'b0, n};
        if (e) return PEC_CODE_HALT;
        return STD_C[n];
    endfunction
    // x11+x9+1 cipher at 100M, then line level toggles on each one
    function logic [4:0] line(input logic [4:0] c);
        logic [4:0] o;
        logic [4:0] s;
        o = c;
        s = c;
        for (int k = 4; k >= 0; k--) begin
            s[k] = c[k] ^ (speed_100 && !c_dis && (lf[10] ^ lf[8]));
            lf = {lf[9:0], lf[10] ^ lf[8]};
            lv = lv ^ s[k];
            o[k] = lv;
        end
        return (c_nrzi && speed_100) ? o : s;
    endfunction
    // nibble source: the mac drives tx_er and holds each nibble until taken
    always @(posedge sys_clk) begin
        if (!tx_nib_valid || tx_nib_ready) begin
            if (tx_nib_valid) expq.push_back(line(enc(tx_nib, tx_er)));
            tx_nib_valid <= (n_off > 0);
            if (n_off > 0) begin
                tx_nib <= n_off[3:0] ^ nib_x;
                tx_er <= er_all | ($urandom % 2 == 1);
                n_off--;
            end
        end
    end
    // code sink with random stalls
    always @(posedge sys_clk) begin
        if (tx_code_valid && tx_code_ready) begin
            if (expq.size() == 0) chk("extra code", 16'(tx_code), 16'h00FF);
            else chk("tx_code", 16'(tx_code), 16'(expq.pop_front()));
        end
        tx_code_ready <= !stall && ($urandom % 4 != 0);
    end
    task automatic settle();
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
    task automatic run_batch(input logic spd, nrzi, inv, dis, erf, stl);
        pec_sta_model_inst.wr(PEC_EXT_CTRL_OFS, {12'h000, nrzi, inv, 1'b0, dis});
        c_nrzi = nrzi;
        c_inv = inv;
        c_dis = dis;
        er_all = erf;
        nib_x = 4'($urandom);
        speed_100 <= spd;
        settle();
        chk("scr_bypass", 16'(scr_bypass), 16'(!spd || dis));
        chk("descr_bypass", 16'(descr_bypass), 16'(!spd || dis));
        stall = stl;
        n_off = 32;
        if (stl) begin
            repeat (12) @(posedge sys_clk);
            #1 chk("full refuses", 16'(tx_nib_ready), 16'h0000);
            stall = 1'b0;
        end
        for (i = 0; i < 3000 && !(n_off == 0 && !tx_nib_valid && expq.size() == 0); i++)
            @(posedge sys_clk);
        if (i == 3000) begin
            n_fail++;
            print_verdict();
        end
    endtask
    task automatic do_reset(input logic [4:0] p);
        addr_led_pins <= p;
        rst_n <= 1'b0;
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        lf = PEC_LFSR_SEED;
        lv = 1'b0;
        repeat (6) @(posedge sys_clk);
        #1 chk("phy_addr", 16'(phy_addr), 16'(p));
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h4479));
        lv = 1'b0;
        stall = 1'b0;
        pins = 5'($urandom);
        aw = {5'h00, pins, 6'h00};
        do_reset(pins);
        pec_sta_model_inst.rd(PEC_EXT_CTRL_OFS, rv);
        chk("reset read", rv, 16'h0008 | aw);
        chk("force_unlock", 16'(descr_force_unlock), 16'h0000);
        // reserved and address bits ignored on a careless write
        pec_sta_model_inst.cyc(1'b1, PEC_EXT_CTRL_OFS, 16'h7FFF);
        pec_sta_model_inst.rd(PEC_EXT_CTRL_OFS, rv);
        chk("reserved read", rv, 16'h002D | aw);
        chk("force_unlock", 16'(descr_force_unlock), 16'h0001);
        chk("addr field", 16'(rv[10:6]), 16'(pins));
        // arm, then a write elsewhere consumes the arming
        pec_sta_model_inst.wr(PEC_EXT_CTRL_OFS, 16'h8008);
        settle();
        chk("override armed", 16'(cmd_override_en), 16'h0001);
        pec_sta_model_inst.rd(PEC_EXT_CTRL_OFS, rv);
        chk("armed read", rv, 16'h8008 | aw);
        pec_sta_model_inst.wr(5'h00, 16'h1234);
        settle();
        chk("override cleared", 16'(cmd_override_en), 16'h0000);
        pec_sta_model_inst.rd(5'h11, rv);
        chk("other reg", rv, 16'h0000);
        pec_sta_model_inst.arm_wr(16'h0008, 5'h01, 16'h0000);
        settle();
        chk("one shot", 16'(cmd_override_en), 16'h0000);
        // data batches: 10M plain, 10M test table, 100M NRZ, 100M NRZI, 100M scrambled
        run_batch(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
        run_batch(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
        run_batch(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
        run_batch(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
        run_batch(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        // software reset keeps the latched address even if the pins move
        pec_sta_model_inst.wr(PEC_EXT_CTRL_OFS, 16'h0025);
        addr_led_pins <= ~pins;
        sw_rst <= 1'b1;
        @(posedge sys_clk);
        sw_rst <= 1'b0;
        repeat (6) @(posedge sys_clk);
        #1 chk("sw_rst addr", 16'(phy_addr), 16'(pins));
        pec_sta_model_inst.rd(PEC_EXT_CTRL_OFS, rv);
        chk("sw_rst read", rv, 16'h0008 | aw);
        do_reset(~pins);
        print_verdict();
    end
endmodule
`default_nettype wire
